/* File: src/tmw_pkg.sv */
// Package: register map, field codes and timing constants of the 16-bit wave-mode timer
package tmw_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_COUNT = 12'h004;
    localparam logic [11:0] ADDR_CMP_A = 12'h008;
    localparam logic [11:0] ADDR_CMP_B = 12'h00C;
    localparam logic [11:0] ADDR_CAPT = 12'h010;
    localparam logic [11:0] ADDR_FLAGS = 12'h014;
    localparam logic [11:0] ADDR_PINS = 12'h018;
    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACT_A_LSB = 4;
    localparam int CTRL_ACT_B_LSB = 6;
    localparam int CTRL_PRE_LSB = 8;
    localparam int CTRL_DIR_A_BIT = 12;
    localparam int CTRL_DIR_B_BIT = 13;
    // FLAGS bits, write one to clear
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMPA_BIT = 1;
    localparam int FLAG_CMPB_BIT = 2;
    localparam int FLAG_CAPT_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    // Prescale divide factors
    localparam logic [10:0] DIV_8 = 11'h008;
    localparam logic [10:0] DIV_64 = 11'h040;
    localparam logic [10:0] DIV_256 = 11'h100;
    localparam logic [10:0] DIV_1024 = 11'h400;

    typedef enum logic [3:0] {
        TMW_NORMAL = 4'h0,
        TMW_CTC_A = 4'h4,
        TMW_FPWM_8 = 4'h5,
        TMW_FPWM_9 = 4'h6,
        TMW_FPWM_10 = 4'h7,
        TMW_CTC_CAPT = 4'hC,
        TMW_FPWM_CAPT = 4'hE,
        TMW_FPWM_A = 4'hF
    } tmw_mode_t;

    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR = 2'h2,
        ACT_SET = 2'h3
    } tmw_act_t;

    // Prescaler select codes: 0 stops the timer clock
    typedef enum logic [2:0] {
        PRE_STOP = 3'h0,
        PRE_1 = 3'h1,
        PRE_8 = 3'h2,
        PRE_64 = 3'h3,
        PRE_256 = 3'h4,
        PRE_1024 = 3'h5
    } tmw_pre_t;

    typedef struct packed {
        logic dir_b;
        logic dir_a;
        logic rsvd;
        logic [2:0] pre;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [3:0] mode;
    } tmw_ctrl_t;

    typedef struct packed {
        logic capt;
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } tmw_flags_t;
endpackage : tmw_pkg

/* File: src/tmw_timer.sv */
// Top: 16-bit timer with normal, clear-on-match and fast PWM modes behind APB
// Behaviour
// (RQ1) Counting follows wave_mode_sel only; out_action_sel affects only outputs.
// (RQ2) Mode 0 counts up forever, wrapping 0xFFFF to 0x0000.
// (RQ3) Normal mode sets overflow_flag as count becomes zero; hardware never clears it.
// (RQ4) Normal mode accepts a count write at any time.
// (RQ5) Clear-on-match clears count at compare A (mode 4) or capture (mode 12).
// (RQ6) Clear-on-match top is unbuffered; a low top means wrap through 0xFFFF first.
// (RQ7) Clear-on-match, action 1 toggles wave_out_a on every match.
// (RQ8) Wave output reaches pin only when its direction bit is 1.
// (RQ9) Timer clock is pclk divided by 1, 8, 64, 256 or 1024.
// (RQ10) Clear-on-match sets overflow_flag when count passes max to 0x0000.
// (RQ11) Fast PWM counts zero to top, clears next; modes 5-7 top 0xFF/0x1FF/0x3FF.
// (RQ12) Fast PWM mode 14 tops at capture, mode 15 at compare A.
// (RQ13) Non-inverting clears on match and sets at bottom; inverting is reversed.
// (RQ14) Fast PWM sets overflow at top, plus the flag of the top register.
// (RQ15) Fixed top masks compare write bits above the resolution.
// (RQ16) Fast PWM buffers compare A writes, loading them at top.
// (RQ17) Fast PWM capture top is unbuffered; low value means wrap first.
// (RQ18) Compare 0 gives a spike per period; compare equal top gives a constant level.
// (RQ19) Fast PWM action 1 toggles output A only in mode 15.
// (RQ20) Software keeps a register top at 0x0003 or more.
// (RQ21) Software keeps top at or above every compare value.
// (RQ22) Compare match sets its flag on the next timer clock.
// (RQ23) Reset clears each internal wave output state to 0.
// (RQ24) Action 0 leaves output state alone and returns pin to port function.
// (RQ25) Fast PWM action 2 is non-inverting, action 3 inverting.
// (RQ26) Counter and outputs advance only on prescaler enables.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tmw_timer
    import tmw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_a,
    input wire logic port_b,
    output logic pin_a,
    output logic pin_a_oe,
    output logic pin_b,
    output logic pin_b_oe,
    output logic wave_out_a,
    output logic wave_out_b
);
    tmw_ctrl_t ctrl_reg;
    tmw_flags_t flags_reg;
    logic [15:0] count_value_reg;
    logic [15:0] compare_a_value_reg;
    logic [15:0] compare_a_buf_reg;
    logic [15:0] compare_b_value_reg;
    logic [15:0] compare_b_buf_reg;
    logic [15:0] capture_value_reg;
    logic [10:0] pre_cnt_reg;
    logic match_a_reg;
    logic match_b_reg;
    logic block_reg;
    logic wave_a_reg;
    logic wave_b_reg;

    // APB decode
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic hit_ctrl = paddr == ADDR_CTRL;
    wire logic hit_count = paddr == ADDR_COUNT;
    wire logic hit_cmp_a = paddr == ADDR_CMP_A;
    wire logic hit_cmp_b = paddr == ADDR_CMP_B;
    wire logic hit_capt = paddr == ADDR_CAPT;
    wire logic hit_flags = paddr == ADDR_FLAGS;
    wire logic hit_pins = paddr == ADDR_PINS;
    wire logic mapped = hit_ctrl | hit_count | hit_cmp_a | hit_cmp_b | hit_capt
                        | hit_flags | hit_pins;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // Mode decode
    wire logic [3:0] wave_mode_sel = ctrl_reg.mode;
    wire logic [1:0] out_action_sel_a = ctrl_reg.act_a;
    wire logic [1:0] out_action_sel_b = ctrl_reg.act_b;
    wire logic is_ctc = wave_mode_sel == TMW_CTC_A || wave_mode_sel == TMW_CTC_CAPT;
    wire logic is_fpwm = wave_mode_sel == TMW_FPWM_8 || wave_mode_sel == TMW_FPWM_9
                         || wave_mode_sel == TMW_FPWM_10 || wave_mode_sel == TMW_FPWM_CAPT
                         || wave_mode_sel == TMW_FPWM_A;
    wire logic top_is_a = wave_mode_sel == TMW_CTC_A || wave_mode_sel == TMW_FPWM_A;
    wire logic top_is_capt = wave_mode_sel == TMW_CTC_CAPT || wave_mode_sel == TMW_FPWM_CAPT;
    wire logic fixed_top = wave_mode_sel == TMW_FPWM_8 || wave_mode_sel == TMW_FPWM_9
                           || wave_mode_sel == TMW_FPWM_10;

    // Top value selection
    wire logic [15:0] top_value =
        (wave_mode_sel == TMW_FPWM_8) ? TOP_8BIT :  // RQ11
        (wave_mode_sel == TMW_FPWM_9) ? TOP_9BIT :
        (wave_mode_sel == TMW_FPWM_10) ? TOP_10BIT :
        top_is_capt ? capture_value_reg :  // RQ5 RQ12
        top_is_a ? compare_a_value_reg : COUNT_MAX;  // RQ2
    wire logic [15:0] res_mask = fixed_top ? top_value : COUNT_MAX;

    // Prescaler: one-cycle enable per timer clock
    logic [10:0] div_sel;
    always_comb begin
        unique case (tmw_pre_t'(ctrl_reg.pre))
            PRE_8: div_sel = DIV_8;
            PRE_64: div_sel = DIV_64;
            PRE_256: div_sel = DIV_256;
            PRE_1024: div_sel = DIV_1024;
            default: div_sel = 11'h001;
        endcase
    end
    wire logic run = ctrl_reg.pre != PRE_STOP && ctrl_reg.pre <= PRE_1024;
    wire logic tick = run && (pre_cnt_reg >= div_sel - 11'h001);  // RQ9 RQ26

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_reg <= 11'h000;
        end else if (!run || tick) begin
            pre_cnt_reg <= 11'h000;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 11'h001;
        end
    end

    // Counter; a clear-on-match top below the count is missed and the count wraps
    wire logic at_top = count_value_reg == top_value;
    wire logic at_max = count_value_reg == COUNT_MAX;
    wire logic clear_now = (is_ctc || is_fpwm) && at_top && !block_reg;  // RQ5 RQ6 RQ17
    wire logic [15:0] count_next = clear_now ? COUNT_BOTTOM
                                             : count_value_reg + 16'h0001;  // RQ1 RQ2
    // Compare registers are live in normal and clear-on-match, buffered in PWM
    wire logic [15:0] cmp_a_eff = is_fpwm ? compare_a_value_reg : compare_a_value_reg;
    wire logic eq_a = count_value_reg == compare_a_value_reg && !block_reg;  // RQ21
    wire logic eq_b = count_value_reg == compare_b_value_reg && !block_reg;
    wire logic cnt_wr = wr && hit_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_reg <= COUNT_BOTTOM;
            block_reg <= 1'b0;
        end else if (cnt_wr) begin
            count_value_reg <= pwdata[15:0];  // RQ4
            block_reg <= 1'b1;
        end else if (tick) begin
            count_value_reg <= count_next;  // RQ26
            block_reg <= 1'b0;
        end
    end

    // Compare match pulses feed the flags one timer clock later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_reg <= 1'b0;
            match_b_reg <= 1'b0;
        end else if (tick) begin
            match_a_reg <= eq_a;  // RQ22
            match_b_reg <= eq_b;
        end
    end

    // Flag events: overflow on wrap to zero or at PWM top
    // Outside PWM only the pass from max counts; a clear at a lower top is no overflow
    wire logic ovf_ev = tick && (is_fpwm ? at_top && !block_reg : at_max);  // RQ3 RQ10 RQ14
    wire logic capt_ev = tick && wave_mode_sel == TMW_FPWM_CAPT && at_top && !block_reg;  // RQ14
    wire logic top_a_pwm = wave_mode_sel == TMW_FPWM_A;
    wire logic cmpa_ev = tick && (top_a_pwm ? at_top && !block_reg : match_a_reg);  // RQ14 RQ22
    wire logic cmpb_ev = tick && match_b_reg;
    wire logic [3:0] flag_clr = (wr && hit_flags) ? pwdata[3:0] : 4'h0;
    wire logic [3:0] flag_set = {capt_ev, cmpb_ev, cmpa_ev, ovf_ev};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else begin
            // Set wins over a same-cycle clear
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;  // RQ3
        end
    end

    // Compare writes: direct outside PWM, buffered and loaded at top in PWM
    wire logic [15:0] wdata_masked = pwdata[15:0] & res_mask;  // RQ15
    wire logic load_top = tick && is_fpwm && at_top && !block_reg;  // RQ16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_value_reg <= COUNT_BOTTOM;
            compare_a_buf_reg <= COUNT_BOTTOM;
            compare_b_value_reg <= COUNT_BOTTOM;
            compare_b_buf_reg <= COUNT_BOTTOM;
            capture_value_reg <= COUNT_BOTTOM;
        end else begin
            if (wr && hit_cmp_a) begin
                compare_a_buf_reg <= wdata_masked;
            end
            if (wr && hit_cmp_b) begin
                compare_b_buf_reg <= wdata_masked;
            end
            if (wr && hit_cmp_a && !is_fpwm) begin
                compare_a_value_reg <= wdata_masked;  // RQ6
            end else if (load_top) begin
                compare_a_value_reg <= compare_a_buf_reg;  // RQ16
            end
            if (wr && hit_cmp_b && !is_fpwm) begin
                compare_b_value_reg <= wdata_masked;
            end else if (load_top) begin
                compare_b_value_reg <= compare_b_buf_reg;
            end
            if (wr && hit_capt) begin
                capture_value_reg <= pwdata[15:0];  // RQ17
            end
        end
    end

    // Waveform output state
    function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                       input logic eq, input logic bottom,
                                       input logic pwm, input logic tog_ok);
        logic nxt;
        nxt = cur;
        if (pwm) begin
            if (act == ACT_TOGGLE) begin
                if (tog_ok && eq) nxt = !cur;  // RQ19
            end else if (act != ACT_NONE) begin
                // A bottom edge meeting a match is resolved by the caller
                if (eq) nxt = (act == ACT_SET);  // RQ13 RQ25 RQ18
                else if (bottom) nxt = (act == ACT_CLEAR);
            end
        end else if (eq) begin
            unique case (tmw_act_t'(act))
                ACT_TOGGLE: nxt = !cur;  // RQ7
                ACT_CLEAR: nxt = 1'b0;
                ACT_SET: nxt = 1'b1;
                ACT_NONE: nxt = cur;  // RQ24
            endcase
        end
        return nxt;
    endfunction : wave_next

    // Compare equal to top matches on the top tick, so the bottom edge overrides it
    wire logic bottom_ev = load_top;
    wire logic na = wave_next(wave_a_reg, out_action_sel_a, eq_a, bottom_ev, is_fpwm,
                              wave_mode_sel == TMW_FPWM_A);
    wire logic nb = wave_next(wave_b_reg, out_action_sel_b, eq_b, bottom_ev, is_fpwm, 1'b0);
    wire logic na_fix = (is_fpwm && bottom_ev && out_action_sel_a[1])
                        ? !out_action_sel_a[0] : na;  // RQ18
    wire logic nb_fix = (is_fpwm && bottom_ev && out_action_sel_b[1])
                        ? !out_action_sel_b[0] : nb;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_a_reg <= 1'b0;  // RQ23
            wave_b_reg <= 1'b0;
        end else if (tick) begin
            wave_a_reg <= na_fix;  // RQ26
            wave_b_reg <= nb_fix;
        end
    end

    assign wave_out_a = wave_a_reg;
    assign wave_out_b = wave_b_reg;
    // Pin override: direction bit gates visibility, action 0 gives back the port
    assign pin_a = (out_action_sel_a != ACT_NONE) ? wave_a_reg : port_a;  // RQ24
    assign pin_b = (out_action_sel_b != ACT_NONE) ? wave_b_reg : port_b;
    assign pin_a_oe = ctrl_reg.dir_a;  // RQ8
    assign pin_b_oe = ctrl_reg.dir_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tmw_ctrl_t'(CTRL_RESET[13:0]);
        end else if (wr && hit_ctrl) begin
            ctrl_reg <= tmw_ctrl_t'(pwdata[13:0]);  // RQ1
        end
    end

    // Read mux
    wire logic [31:0] rd_mux =
        hit_ctrl ? {18'h00000, ctrl_reg} :
        hit_count ? {16'h0000, count_value_reg} :
        hit_cmp_a ? {16'h0000, (is_fpwm ? compare_a_buf_reg : cmp_a_eff)} :
        hit_cmp_b ? {16'h0000, (is_fpwm ? compare_b_buf_reg : compare_b_value_reg)} :
        hit_capt ? {16'h0000, capture_value_reg} :
        hit_flags ? {28'h0000000, flags_reg} :
        hit_pins ? {28'h0000000, pin_b_oe, pin_a_oe, wave_b_reg, wave_a_reg} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule : tmw_timer

/* File: testbench/tmw_timer_assertions.sv */
// Checker: port-level rules of the wave-mode timer
`timescale 1ns/1ps
module tmw_timer_assertions
    import tmw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic port_a,
    input wire logic pin_a,
    input wire logic pin_a_oe,
    input wire logic pin_b,
    input wire logic pin_b_oe,
    input wire logic wave_out_a,
    input wire logic wave_out_b
);
    // Shadow of the control word, rebuilt from bus writes
    logic [31:0] ctrl_reg;
    logic stop_reg;
    wire logic ctrl_wr = psel && penable && pwrite && paddr == ADDR_CTRL;
    wire logic mapped = paddr <= ADDR_PINS && paddr[1:0] == 2'h0;
    wire logic stopped = ctrl_reg[10:8] == 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            stop_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_wr ? pwdata : ctrl_reg;
            stop_reg <= stopped;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_err_unmapped; psel && penable && !mapped |-> pslverr; endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
    property p_err_mapped; psel && penable && mapped |-> !pslverr; endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("error on mapped");
    property p_oe; {pin_b_oe, pin_a_oe} == ctrl_reg[13:12]; endproperty
    a_oe: assert property (p_oe) else $error("pin enables differ from dir bits");
    property p_port_a; ctrl_reg[5:4] == 2'h0 |-> pin_a == port_a; endproperty
    a_port_a: assert property (p_port_a) else $error("pin a lost port function");
    property p_wave_a; ctrl_reg[5:4] != 2'h0 |-> pin_a == wave_out_a; endproperty
    a_wave_a: assert property (p_wave_a) else $error("pin a not wave state");
    property p_wave_b; ctrl_reg[7:6] != 2'h0 |-> pin_b == wave_out_b; endproperty
    a_wave_b: assert property (p_wave_b) else $error("pin b not wave state");
    property p_reset; $rose(presetn) |-> !wave_out_a && !wave_out_b; endproperty
    a_reset: assert property (p_reset) else $error("wave state not cleared");
    // Two stopped cycles in a row, so a tick already in flight is not blamed
    property p_stop; stop_reg && stopped && !ctrl_wr |=> $stable({wave_out_a, wave_out_b});
    endproperty
    a_stop: assert property (p_stop) else $error("wave moved while stopped");
    c_pwm_a: cover property (ctrl_wr && pwdata[3:0] == 4'hF);
    c_rise: cover property (pin_a_oe && $rose(pin_a));
    c_err: cover property (psel && penable && pslverr);
endmodule : tmw_timer_assertions

bind tmw_timer tmw_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .port_a(port_a), .pin_a(pin_a), .pin_a_oe(pin_a_oe), .pin_b(pin_b),
    .pin_b_oe(pin_b_oe), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));

/* File: testbench/tmw_load.sv */
// Partner: external load on one wave pin
`timescale 1ns/1ps
module tmw_load (
    input wire logic pin,
    input wire logic pin_oe,
    output logic level
);
    // Pull-down: a released pin reads low, never the last driven level
    assign level = pin_oe ? pin : 1'b0;
endmodule : tmw_load

/* File: testbench/tmw_timer_test.sv */
// Testbench: APB-driven scenarios for the wave-mode timer
`timescale 1ns/1ps
module tmw_timer_test
    import tmw_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic port_a = 1'b0;
    logic port_b = 1'b1;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, pin_a, pin_a_oe, pin_b, pin_b_oe, wave_out_a, wave_out_b, level_a;
    logic err;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int hi, per;
    always #2 pclk = ~pclk;
    tmw_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a(port_a), .port_b(port_b), .pin_a(pin_a),
        .pin_a_oe(pin_a_oe), .pin_b(pin_b), .pin_b_oe(pin_b_oe), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b));
    tmw_load load_a (.pin(pin_a), .pin_oe(pin_a_oe), .level(level_a));
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // One transfer plus an idle cycle, so back-to-back calls never reassign psel at one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Rise-to-rise period of the loaded pin and its high cycles
    task automatic measure();
        logic last;
        @(posedge level_a);
        hi = 0;
        per = 0;
        do begin
            last = level_a;
            @(posedge pclk);
            #1;
            per++;
            hi += int'(level_a);
        end while (!(level_a === 1'b1 && last === 1'b0));
    endtask : measure
    task automatic t_reset();
        port_a <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", rd, CTRL_RESET);
        apb(1'b0, 12'h01C, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        check("wave a", 32'(wave_out_a), 32'h0);
        check("pin a port", 32'(pin_a), 32'h1);
        check("pin b port", 32'(pin_b), 32'(port_b));
        $display("t_reset done");
    endtask : t_reset
    task automatic t_normal();
        apb(1'b1, ADDR_COUNT, 32'h0000_FFF8);
        apb(1'b1, ADDR_CMP_B, 32'h0000_0005);
        apb(1'b1, ADDR_FLAGS, 32'h0000_000F);
        // Action B set-on-match must not change the count sequence
        apb(1'b1, ADDR_CTRL, 32'h0000_21C0);
        repeat (20) @(posedge pclk);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        check("wrap", rd, 32'h0000_000F);
        check("wave b held", 32'(wave_out_b), 32'h1);
        apb(1'b1, ADDR_FLAGS, 32'h0);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check("ovf", 32'(rd[FLAG_OVF_BIT]), 32'h1);
        check("cmp b flag", 32'(rd[FLAG_CMPB_BIT]), 32'h1);
        $display("t_normal done");
    endtask : t_normal
    task automatic t_ctc();
        logic [2:0] codes [5] = '{PRE_1, PRE_8, PRE_64, PRE_256, PRE_1024};
        int divs [5] = '{1, 8, 64, 256, 1024};
        apb(1'b1, ADDR_CMP_A, 32'h3);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'h0000_000F);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h0000_1014 | (32'(codes[i]) << CTRL_PRE_LSB));
            measure();
            check("ctc period", per, 8 * divs[i]);
            check("ctc high", hi, 4 * divs[i]);
        end
        apb(1'b1, ADDR_CTRL, 32'h0000_0014);
        check("oe off", 32'(pin_a_oe), 32'h0);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check("ctc flags", rd & 32'h3, 32'h2);
        $display("t_ctc done");
    endtask : t_ctc
    task automatic t_fpwm();
        apb(1'b1, ADDR_CTRL, 32'h0000_1025);
        apb(1'b1, ADDR_CMP_A, 32'h0000_FF40);
        apb(1'b0, ADDR_CMP_A, 32'h0);
        check("masked cmp", rd, 32'h0000_0040);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, ADDR_CTRL, 32'h0000_1125 + m);
            measure();
            check("fpwm period", per, 256 << m);
        end
        apb(1'b1, ADDR_CTRL, 32'h0000_1125);
        measure();
        check("non-inv high", hi, 65);
        apb(1'b1, ADDR_CTRL, 32'h0000_1135);
        measure();
        check("inv high", hi, 191);
        apb(1'b1, ADDR_CMP_A, 32'h0000_00FF);
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, ADDR_CTRL, 32'h0000_1135 - 32'(p << 4));
            repeat (600) @(posedge pclk);
            hi = 0;
            repeat (256) begin
                @(posedge pclk);
                #1;
                hi += int'(level_a);
            end
            check("top level", hi, 256 * p);
        end
        $display("t_fpwm done");
    endtask : t_fpwm
    task automatic t_tops();
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CAPT, 32'h7);
        apb(1'b1, ADDR_CMP_A, 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h0000_112E);
        measure();
        check("capt top", per, 8);
        apb(1'b1, ADDR_FLAGS, 32'h0000_000F);
        repeat (10) @(posedge pclk);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check("top flags", rd & 32'h9, 32'h9);
        // Stop and rewind so the smaller compare top is not overrun
        apb(1'b1, ADDR_CTRL, 32'h0000_002E);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0000_111F);
        measure();
        check("toggle period", per, 8);
        apb(1'b1, ADDR_CMP_A, 32'h9);
        measure();
        check("buffered top", per, 20);
        check("toggle duty", hi, 10);
        $display("t_tops done");
    endtask : t_tops
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_normal();
        t_ctc();
        t_fpwm();
        t_tops();
        print_verdict();
    end
endmodule : tmw_timer_test
